// *** hdl/brg_top.sv ***
// Local design decisions: register access over APB and the placing of the registers.
`timescale 1ns/1ps
`include "brg_consts.svh"

// Notes on behaviour
// - timer counts down, reloads, pulses on underflow
// - timer clocked by fractional or prescaler output
// - fractional mode: run bit starts, stops timer
// - enable with normal divider mode halts timer
// - prescaler divides by two to prescale_select
// - fractional ratio is step over 256
// - counts between pulses equal reload plus one
module brg_top (
	// clock and reset
	input  wire logic          ref_clk,
	input  wire logic          reset,
	// apb slave
	input  brg_pkg::brg_apb_req_t apb_req,
	output brg_pkg::brg_apb_rsp_t apb_rsp,
	// baud clock to the serial channel
	output logic               baud_tick,
	// fractional divider output pulse
	output logic               frac_div_output_clock
);
	import brg_pkg::*;

	brg_top_state_t st_reg;      // registered state
	brg_top_state_t st_next;     // next state
	logic           pre_tick;    // prescaler output enable
	logic           frac_tick;   // fractional divider pulse
	logic           timer_clk;   // selected timer clock enable
	logic           timer_halt;  // normal divider mode halt
	logic           running;     // timer allowed to count
	logic           wr_strobe;   // apb write takes effect
	logic           setup;       // apb setup cycle

	// mask of low prescaler bits for a division by 2**sel
	function automatic logic [7:0] presc_mask(input logic [2:0] sel);
		presc_mask = 8'((9'h001 << sel) - 9'h001);
	endfunction

	// true if the byte offset is one of ours
	function automatic logic addr_mapped(input logic [11:0] a);
		addr_mapped = (a == `BRG_OFF_BAUD_CONTROL) || (a == `BRG_OFF_BAUD_RELOAD) ||
			(a == `BRG_OFF_FRAC_CONTROL) || (a == `BRG_OFF_FRAC_STEP) ||
			(a == `BRG_OFF_STATUS);
	endfunction

	// read mux shared by the setup-phase capture
	function automatic logic [31:0] read_word(input brg_top_state_t s, input logic [11:0] a,
			input logic r);
		read_word = `BRG_RST_WORD;
		case (a)
			`BRG_OFF_BAUD_CONTROL: begin
				read_word[`BRG_RUN_BIT] = s.run;
				read_word[`BRG_PRESC_MSB:`BRG_PRESC_LSB] = s.presc;
			end
			`BRG_OFF_BAUD_RELOAD: begin
				read_word[7:0] = s.reload;
			end
			`BRG_OFF_FRAC_CONTROL: begin
				read_word[`BRG_FRAC_EN_BIT] = s.frac_en;
				read_word[`BRG_FRAC_MODE_BIT] = s.frac_mode;
			end
			`BRG_OFF_FRAC_STEP: begin
				read_word[7:0] = s.step;
			end
			`BRG_OFF_STATUS: begin
				read_word[`BRG_STAT_CNT_MSB:0] = s.cnt;
				read_word[`BRG_STAT_RUN_BIT] = r;
			end
			default: begin
				read_word = `BRG_RST_WORD;
			end
		endcase
	endfunction

	// prescaler ticks when the low sel bits are all ones
	assign pre_tick = (st_reg.pcnt & presc_mask(st_reg.presc)) == presc_mask(st_reg.presc);

	// fractional divider is fed from the prescaler output
	brg_frac_div u_frac (
		.ref_clk               (ref_clk),
		.reset                 (reset),
		.in_tick               (pre_tick),
		.frac_div_enable       (st_reg.frac_en),
		.frac_div_mode_select  (st_reg.frac_mode),
		.step                  (st_reg.step),
		.frac_div_output_clock (frac_tick)
	);

	// clock source selected by the enable bit
	assign timer_clk = st_reg.frac_en ? frac_tick : pre_tick;
	// normal divider mode overrides the run bit
	assign timer_halt = st_reg.frac_en && st_reg.frac_mode;
	// run bit gates the timer otherwise
	assign running = st_reg.run && !timer_halt;

	// apb phases; zero wait states so pready is high in every access
	assign setup     = apb_req.psel && !apb_req.penable;
	assign wr_strobe = apb_req.psel && apb_req.penable && st_reg.rsp.pready &&
		apb_req.pwrite && !st_reg.rsp.pslverr;

	// next-state logic
	always_comb begin
		st_next = st_reg;
		st_next.tick = 1'b0;
		// free-running prescaler count; wraps cleanly for every sel
		st_next.pcnt = st_reg.pcnt + 8'h01;

		// count down, reload and pulse on underflow
		if (running && timer_clk) begin
			if (st_reg.cnt == 8'h00) begin
				// reload gives reload plus one counts
				st_next.cnt = st_reg.reload;
				st_next.tick = 1'b1;
			end else begin
				st_next.cnt = st_reg.cnt - 8'h01;
			end
		end

		// answer is prepared in setup so it is ready in the access phase
		st_next.rsp.pready = setup;
		if (setup) begin
			st_next.rsp.pslverr = !addr_mapped(apb_req.paddr);
			st_next.rsp.prdata = apb_req.pwrite ? `BRG_RST_WORD :
				read_word(st_reg, apb_req.paddr, running);
		end else begin
			st_next.rsp.pslverr = 1'b0;
			st_next.rsp.prdata = `BRG_RST_WORD;
		end

		// register writes at the completing access edge
		if (wr_strobe) begin
			case (apb_req.paddr)
				`BRG_OFF_BAUD_CONTROL: begin
					st_next.run = apb_req.pwdata[`BRG_RUN_BIT];
					st_next.presc = apb_req.pwdata[`BRG_PRESC_MSB:`BRG_PRESC_LSB];
				end
				`BRG_OFF_BAUD_RELOAD: begin
					st_next.reload = apb_req.pwdata[7:0];
				end
				`BRG_OFF_FRAC_CONTROL: begin
					st_next.frac_en = apb_req.pwdata[`BRG_FRAC_EN_BIT];
					st_next.frac_mode = apb_req.pwdata[`BRG_FRAC_MODE_BIT];
				end
				`BRG_OFF_FRAC_STEP: begin
					st_next.step = apb_req.pwdata[7:0];
				end
				default: begin
					// status is read only; writes ignored
					st_next.run = st_reg.run;
				end
			endcase
		end
	end

	// state register
	always_ff @(posedge ref_clk) begin
		if (reset) begin
			st_reg <= '0;
		end else begin
			st_reg <= st_next;
		end
	end

	// outputs straight from flops
	assign apb_rsp               = st_reg.rsp;
	assign baud_tick             = st_reg.tick;
	assign frac_div_output_clock = frac_tick;

	// helper: fast fixed configuration with reload of two
	logic cfg_fast;
	assign cfg_fast = (st_reg.presc == 3'h0) && !st_reg.frac_en && st_reg.run &&
		(st_reg.reload == 8'h02);

	// underflow reloads and pulses next cycle
	a_reload_on_under: assert property (@(posedge ref_clk) disable iff (reset)
		(running && timer_clk && st_reg.cnt == 8'h00)
		|=> baud_tick && st_reg.cnt == $past(st_reg.reload))
		else $error("underflow did not reload and pulse");

	// no pulse without an underflow
	a_pulse_has_cause: assert property (@(posedge ref_clk) disable iff (reset)
		baud_tick |-> $past(running && timer_clk && st_reg.cnt == 8'h00))
		else $error("baud pulse without underflow");

	// prescaler clocks the timer when fractional is off
	a_presc_source: assert property (@(posedge ref_clk) disable iff (reset)
		(!st_reg.frac_en && st_reg.run && pre_tick && st_reg.cnt != 8'h00)
		|=> st_reg.cnt == 8'($past(st_reg.cnt) - 8'h01))
		else $error("prescaler tick did not decrement timer");

	// with fractional on, prescaler ticks alone do not count
	a_frac_source: assert property (@(posedge ref_clk) disable iff (reset)
		(st_reg.frac_en && !frac_tick) |=> $stable(st_reg.cnt))
		else $error("timer moved without fractional pulse");

	// cleared run bit stops the timer
	a_run_stop: assert property (@(posedge ref_clk) disable iff (reset)
		(!st_reg.run) |=> $stable(st_reg.cnt) && !baud_tick)
		else $error("timer moved while run clear");

	// normal divider mode halts the timer whatever run says
	a_normal_halt: assert property (@(posedge ref_clk) disable iff (reset)
		(st_reg.frac_en && st_reg.frac_mode) |=> !baud_tick && $stable(st_reg.cnt))
		else $error("timer ran in normal divider mode");

	// divide by four gives three quiet cycles after a tick
	a_presc_rate: assert property (@(posedge ref_clk) disable iff (reset)
		(pre_tick && st_reg.presc == 3'h2)
		|=> (!pre_tick || st_reg.presc != 3'h2)[*3])
		else $error("prescaler divide by four broken");

	// reload two gives a pulse every three counts
	a_reload_count: assert property (@(posedge ref_clk) disable iff (reset)
		(baud_tick && cfg_fast)
		|=> (!baud_tick || !cfg_fast)[*2] ##1 (baud_tick || !cfg_fast))
		else $error("reload plus one spacing broken");

endmodule

// *** hdl/brg_consts.svh ***
`ifndef BRG_CONSTS_SVH
`define BRG_CONSTS_SVH

// register byte offsets
`define BRG_OFF_BAUD_CONTROL  12'h000
`define BRG_OFF_BAUD_RELOAD   12'h004
`define BRG_OFF_FRAC_CONTROL  12'h008
`define BRG_OFF_FRAC_STEP     12'h00C
`define BRG_OFF_STATUS        12'h010

// baud_control fields
`define BRG_RUN_BIT           0
`define BRG_PRESC_LSB         1
`define BRG_PRESC_MSB         3
// frac_div_control fields
`define BRG_FRAC_EN_BIT       0
`define BRG_FRAC_MODE_BIT     1
// status fields
`define BRG_STAT_CNT_MSB      7
`define BRG_STAT_RUN_BIT      8

// reset values
`define BRG_RST_BYTE          8'h00
`define BRG_RST_PRESC         3'h0
`define BRG_RST_WORD          32'h0000_0000

`endif

// *** hdl/brg_pkg.sv ***
package brg_pkg;

	// apb request as seen by the slave
	typedef struct packed {
		logic        psel;
		logic        penable;
		logic        pwrite;
		logic [11:0] paddr;
		logic [31:0] pwdata;
	} brg_apb_req_t;

	// apb answer driven by the slave
	typedef struct packed {
		logic        pready;
		logic [31:0] prdata;
		logic        pslverr;
	} brg_apb_rsp_t;

	// whole state of the top module
	typedef struct packed {
		logic         run;
		logic [2:0]   presc;
		logic [7:0]   reload;
		logic         frac_en;
		logic         frac_mode;
		logic [7:0]   step;
		logic [7:0]   pcnt;
		logic [7:0]   cnt;
		logic         tick;
		brg_apb_rsp_t rsp;
	} brg_top_state_t;

	// whole state of the fractional divider
	typedef struct packed {
		logic [7:0] acc;
		logic       out;
	} brg_frac_state_t;

endpackage

// *** hdl/brg_frac_div.sv ***
`timescale 1ns/1ps
`include "brg_consts.svh"

module brg_frac_div (
	// clock and reset
	input  wire logic       ref_clk,
	input  wire logic       reset,
	// control
	input  wire logic       in_tick,
	input  wire logic       frac_div_enable,
	input  wire logic       frac_div_mode_select,
	input  wire logic [7:0] step,
	// output pulse
	output logic            frac_div_output_clock
);
	import brg_pkg::*;

	brg_frac_state_t st_reg;   // registered state
	brg_frac_state_t st_next;  // next state
	logic [8:0]      sum;      // accumulator plus step with carry

	// next-state logic
	always_comb begin
		st_next = st_reg;
		st_next.out = 1'b0;
		sum = {1'b0, st_reg.acc} + {1'b0, step};
		if (!frac_div_enable) begin
			// disabled: park accumulator so a later enable starts clean
			st_next.acc = `BRG_RST_BYTE;
		end else if (in_tick && !frac_div_mode_select) begin
			st_next.acc = sum[7:0];
			st_next.out = sum[8];
		end else if (in_tick) begin
			// normal divider: divide by 256 minus step
			if (st_reg.acc == 8'hFF) begin
				st_next.acc = step;
				st_next.out = 1'b1;
			end else begin
				st_next.acc = st_reg.acc + 8'h01;
			end
		end
	end

	// state register
	always_ff @(posedge ref_clk) begin
		if (reset) begin
			st_reg <= '0;
		end else begin
			st_reg <= st_next;
		end
	end

	assign frac_div_output_clock = st_reg.out;

	// carry of a fractional add must give one pulse
	a_frac_carry_pulse: assert property (@(posedge ref_clk) disable iff (reset)
		(frac_div_enable && !frac_div_mode_select && in_tick && sum[8])
		|=> frac_div_output_clock)
		else $error("fractional carry gave no pulse");

	// in fractional mode the accumulator moves by step on each input tick
	a_frac_acc_step: assert property (@(posedge ref_clk) disable iff (reset)
		(frac_div_enable && !frac_div_mode_select && in_tick)
		|=> st_reg.acc == 8'($past(st_reg.acc) + $past(step)))
		else $error("accumulator did not add step");

endmodule

// *** bench/brg_serial_sink.sv ***
`timescale 1ns/1ps

// far side: serial channel that takes one bit slot per baud pulse
module brg_serial_sink (
	// clock and reset
	input  wire logic        ref_clk,
	input  wire logic        reset,
	// baud clock from the generator
	input  wire logic        baud_tick,
	// pulse count and last spacing
	output logic      [31:0] n_pulses,
	output logic      [31:0] gap
);
	logic [31:0] since_reg; // cycles since last pulse

	// gap counts edges between pulses so divide ratios read directly
	// one slot per pulse
	always_ff @(posedge ref_clk) begin
		if (reset) begin
			n_pulses  <= 32'h0;
			gap       <= 32'h0;
			since_reg <= 32'h0;
		end else if (baud_tick === 1'b1) begin
			n_pulses  <= n_pulses + 32'h1;
			gap       <= since_reg + 32'h1;
			since_reg <= 32'h0;
		end else begin
			since_reg <= since_reg + 32'h1;
		end
	end
endmodule

// *** bench/test_brg_top.sv ***
`timescale 1ns/1ps

module test_brg_top;
	import brg_pkg::*;
	// design side
	logic         ref_clk;
	logic         reset;
	brg_apb_req_t apb_req;
	brg_apb_rsp_t apb_rsp;
	logic         baud_tick;
	logic         frac_clk;
	// partner side
	logic  [31:0] n_pulses;
	logic  [31:0] gap;
	logic  [31:0] q;
	logic         e;
	logic  [31:0] snap;
	// bookkeeping
	int           n_errors;
	int           checks_done;
	int           cycles;

	brg_top uut (
		.ref_clk               (ref_clk),
		.reset                 (reset),
		.apb_req               (apb_req),
		.apb_rsp               (apb_rsp),
		.baud_tick             (baud_tick),
		.frac_div_output_clock (frac_clk)
	);

	brg_serial_sink sink (
		.ref_clk   (ref_clk),
		.reset     (reset),
		.baud_tick (baud_tick),
		.n_pulses  (n_pulses),
		.gap       (gap)
	);

	// free running 250 MHz clock
	initial begin
		ref_clk = 1'b0;
		forever #2 ref_clk = ~ref_clk;
	end

	// hang guard, far above the few hundred cycles the tests take
	always @(posedge ref_clk) begin
		cycles++;
		if (cycles == 20000) begin
			n_errors++;
			end_sim();
		end
	end

	task end_sim();
		$display("checks %0d mismatches %0d", checks_done, n_errors);
		if (n_errors == 0 && checks_done > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask

	task chk(input logic [31:0] got, input logic [31:0] exp, input string what);
		checks_done++;
		if (got !== exp) begin
			n_errors++;
			$display("MISMATCH t=%0t %s got %h exp %h", $time, what, got, exp);
		end
	endtask

	// one apb transfer; request held until pready is seen high
	task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		@(posedge ref_clk);
		apb_req.psel    <= 1'b1;
		apb_req.penable <= 1'b0;
		apb_req.pwrite  <= w;
		apb_req.paddr   <= a;
		apb_req.pwdata  <= d;
		@(posedge ref_clk);
		apb_req.penable <= 1'b1;
		// no wait count assumed; only the hang guard ends a stuck transfer
		do begin
			@(posedge ref_clk);
		end while (apb_rsp.pready !== 1'b1);
		q = apb_rsp.prdata;
		e = apb_rsp.pslverr;
		apb_req.psel    <= 1'b0;
		apb_req.penable <= 1'b0;
	endtask

	// wait for k more baud pulses; the hang guard bounds it
	task wait_n(input int k);
		snap = n_pulses;
		while (n_pulses < snap + k) begin
			@(posedge ref_clk);
		end
	endtask

	task t_reset();
		for (int a = 0; a <= 16; a += 4) begin
			apb(1'b0, 12'(a), 32'h0);
			chk(q, 32'h0, "reset value");
			chk({31'h0, e}, 32'h0, "no error");
		end
		apb(1'b0, 12'h014, 32'h0);
		chk({31'h0, e}, 32'h1, "unmapped error");
		apb(1'b1, 12'h010, 32'hFFFF_FFFF);
		apb(1'b0, 12'h010, 32'h0);
		chk(q, 32'h0, "status read only");
		$display("test reset done");
	endtask

	task t_timer();
		apb(1'b1, 12'h004, 32'h2);
		apb(1'b1, 12'h000, 32'h1);
		wait_n(3);
		chk(gap, 32'h3, "reload plus one");
		apb(1'b0, 12'h010, 32'h0);
		chk(q & 32'h100, 32'h100, "running flag");
		apb(1'b1, 12'h000, 32'h5);
		wait_n(3);
		chk(gap, 32'hC, "prescale by four");
		$display("test timer done");
	endtask

	task t_stop();
		apb(1'b1, 12'h000, 32'h0);
		repeat (3) @(posedge ref_clk);
		snap = n_pulses;
		repeat (40) @(posedge ref_clk);
		chk(n_pulses, snap, "run clear stops");
		$display("test stop done");
	endtask

	task t_frac();
		int n;
		apb(1'b1, 12'h004, 32'h1);
		apb(1'b1, 12'h00C, 32'h40);
		apb(1'b1, 12'h008, 32'h1);
		apb(1'b1, 12'h000, 32'h1);
		wait_n(3);
		chk(gap, 32'h8, "step 64 of 256");
		// step 64 carries once every four prescaler ticks
		n = 0;
		repeat (16) begin
			@(posedge ref_clk);
			if (frac_clk === 1'b1) n++;
		end
		chk(n, 32'h4, "fractional pulse rate");
		apb(1'b0, 12'h00C, 32'h0);
		chk(q, 32'h40, "step readback");
		apb(1'b1, 12'h008, 32'h3);
		repeat (3) @(posedge ref_clk);
		snap = n_pulses;
		repeat (40) @(posedge ref_clk);
		chk(n_pulses, snap, "normal mode halts");
		apb(1'b0, 12'h010, 32'h0);
		chk(q & 32'h100, 32'h0, "not running");
		apb(1'b0, 12'h008, 32'h0);
		chk(q, 32'h3, "normal mode readback");
		$display("test fractional done");
	endtask

	// main sequence
	initial begin
		n_errors    = 0;
		checks_done = 0;
		cycles      = 0;
		reset       = 1'b1;
		apb_req     = '0;
		repeat (2) @(posedge ref_clk);
		reset <= 1'b0;
		t_reset();
		t_timer();
		t_stop();
		t_frac();
		end_sim();
	end
endmodule
